//--- verilog/cml_pkg.sv
// How it works
// [RQ1] mode pins pick one of seven loading modes
// [RQ2] oscillator slow when select high, else fast
// [RQ3] drive config clock in master/peripheral, else input
// [RQ4] master parallel: 18-bit address, byte per read clock
// [RQ5] bytes leave least significant bit first
// [RQ6] address starts at zero, increments per byte
// [RQ7] daisy output changes on config clock falling edge
// [RQ8] config clock runs eight times read clock
// [RQ9] master serial loads at start and on request
// [RQ10] master serial takes bit on clock rising edge
// [RQ11] initialization starts by itself after reset
// [RQ12] done low while loading, high when finished
// [RQ13] init status low at start of reconfiguration
// [RQ14] host pulses program request low for 500 ns
// [RQ15] processor writes bytes with chip selects, strobe
// [RQ16] ready/busy low while hold register full
// [RQ17] hold moves to empty shifter at once
// [RQ18] hold waits while shifter still busy
// [RQ19] processor waits for ready before next write
// [RQ20] ready/busy on data bit 7 during read
// [RQ21] data bits 6..0 never driven
// [RQ22] processor may wait worst busy time instead
// [RQ23] master serial preferably uses slow oscillator
// [RQ24] bit stream error idles with init low
// [RQ25] mode sampled at start, fixed until end
package cml_pkg;

  // ****************************************
  // clocking and timing
  // ****************************************
  localparam int unsigned REF_CLK_HZ    = 40_000_000;  // ref_clk rate
  localparam int unsigned OSC_SLOW_HZ   = 1_250_000;   // selected when select pin high
  localparam int unsigned OSC_FAST_HZ   = 10_000_000;  // selected when select pin low
  localparam logic [4:0]  HALF_SLOW     = 5'(REF_CLK_HZ / (2 * OSC_SLOW_HZ));
  localparam logic [4:0]  HALF_FAST     = 5'(REF_CLK_HZ / (2 * OSC_FAST_HZ));
  localparam int unsigned PROG_PULSE_NS = 500;         // host request pulse width
  localparam int unsigned REF_PERIOD_NS = 25;
  localparam logic [4:0]  PROG_PULSE_CYC =
    5'((PROG_PULSE_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
  localparam logic [4:0]  INIT_CYCLES   = 5'h08;       // init phase length

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int unsigned ADDR_W     = 18;
  localparam logic [17:0] ADDR_RESET = 18'h00000;
  localparam logic [2:0]  BYTE_LAST  = 3'h7; // index of eighth bit
  localparam logic [3:0]  BYTE_BITS  = 4'h8;

  // ****************************************
  // modes and states
  // ****************************************
  typedef enum logic [2:0] {
    CML_MASTER_SERIAL = 3'b000,
    CML_SLAVE_PARALLEL = 3'b001,
    CML_CPU_BUS_A     = 3'b010,
    CML_CPU_BUS_B     = 3'b011,
    CML_MASTER_PAR    = 3'b100,
    CML_ASYNC_PERIPH  = 3'b101,
    CML_RESERVED      = 3'b110,
    CML_SLAVE_SERIAL  = 3'b111
  } cmlMode_t;

  typedef enum logic [1:0] {
    CML_ST_INIT  = 2'b00,
    CML_ST_LOAD  = 2'b01,
    CML_ST_DONE  = 2'b10,
    CML_ST_ERROR = 2'b11
  } cmlState_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic chipSelectLowN;   // active low select
    logic chipSelectHigh;   // active high select
    logic writeN;           // write strobe, active low
    logic readN;            // read strobe, active low
  } cmlHostBus_t;

  typedef struct packed {
    logic bitValue;         // serialized configuration bit
    logic valid;            // one-cycle strobe
  } cmlStream_t;

endpackage : cml_pkg

//--- verilog/cml_sync.sv
`timescale 1ns/1ps
// ****************************************
// two flip-flop synchronizer
// ****************************************
module cml_sync #(
  parameter int unsigned W = 1
) (
  // clock
  input  wire logic         clk,
  // asynchronous level in, synchronized level out
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1_q;  // metastable stage, read only by stage two

  // no reset: a constant would hide the pin level for two cycles only
  always_ff @(posedge clk) begin
    stage1_q <= asyncIn;
    syncOut  <= stage1_q;
  end
endmodule : cml_sync

//--- verilog/cml_serializer.sv
`timescale 1ns/1ps
// ****************************************
// double-buffered hold and shift registers
// ****************************************
module cml_serializer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       clear,
  // byte side
  input  wire logic       load,
  input  wire logic [7:0] loadByte,
  output logic            holdFull,
  // bit side
  input  wire logic       step,
  output logic            bitValid,
  output logic            bitOut
);
  import cml_pkg::*;

  logic [7:0] hold_q;      // holding register
  logic [7:0] shift_q;     // shift register
  logic [3:0] left_q;      // bits still in shifter, zero when empty
  logic       holdFull_q;

  wire shiftEmpty = (left_q == 4'h0);
  wire moveHold   = holdFull_q && shiftEmpty;   // [RQ17]
  wire doShift    = step && !shiftEmpty;        // hold waits here [RQ18]

  assign holdFull = holdFull_q;
  assign bitValid = doShift;
  assign bitOut   = shift_q[0]; // [RQ5]

  // hold register fill and drain; a load on a full hold is dropped
  always_ff @(posedge clk) begin
    if (clear) begin
      holdFull_q <= 1'b0;
      hold_q     <= 8'h00;
    end else if (load && !holdFull_q) begin
      holdFull_q <= 1'b1;
      hold_q     <= loadByte;
    end else if (moveHold) begin
      holdFull_q <= 1'b0;
    end
  end

  // shifter: right shift so bit 0 leaves first
  always_ff @(posedge clk) begin
    if (clear) begin
      left_q  <= 4'h0;
      shift_q <= 8'h00;
    end else if (moveHold) begin
      left_q  <= BYTE_BITS;
      shift_q <= hold_q;
    end else if (doShift) begin
      left_q  <= left_q - 4'h1;
      shift_q <= {1'b0, shift_q[7:1]}; // [RQ5]
    end
  end
endmodule : cml_serializer

//--- verilog/cml_loader.sv
`timescale 1ns/1ps
module cml_loader
  import cml_pkg::*;
(
  // system clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // configuration clock, external in slave modes, driven in all other modes but reserved
  input  wire logic              configClockIn,
  output logic                   configClockOut,
  output logic                   configClockOe,
  // mode straps and program request
  input  wire logic              modeSelectBit0,
  input  wire logic              modeSelectBit1,
  input  wire logic              modeSelectBit2,
  input  wire logic              oscFreqSelect,
  input  wire logic              programRequestN,
  // serial data in
  input  wire logic              serialDataIn,
  // byte-wide memory
  output logic      [ADDR_W-1:0] memAddr,
  output logic                   memReadClock,
  input  wire logic [7:0]        memData,
  // processor port
  input  wire cmlHostBus_t       hostBus,
  input  wire logic [7:0]        dataIn,
  output logic                   statusDataLineOut,
  output logic                   statusDataLineOe,
  output logic                   readyBusy,
  // daisy chain
  output logic                   daisyOut,
  // status pins
  output logic                   initN,
  output logic                   done,
  // toward configuration memory and frame checker
  output cmlStream_t             cfgStream,
  input  wire logic              bitstreamError,
  input  wire logic              loadFinished
);

  // ****************************************
  // pin synchronizers
  // ****************************************
  logic [2:0]  modePinsS;     // synchronized mode straps
  logic        oscSlowS;      // synchronized frequency select
  logic        progNS;        // synchronized program request
  logic        serDinS;       // synchronized serial data
  cmlHostBus_t hostS;         // synchronized processor strobes
  logic [7:0]  dataS;         // synchronized processor data
  logic [7:0]  memDataS;      // synchronized memory data

  cml_sync #(.W(26)) pinSync (
    .clk     (ref_clk),
    .asyncIn ({modeSelectBit2, modeSelectBit1, modeSelectBit0, oscFreqSelect,
               programRequestN, serialDataIn, hostBus, dataIn, memData}),
    .syncOut ({modePinsS, oscSlowS, progNS, serDinS, hostS, dataS, memDataS})
  );

  // ****************************************
  // state and mode registers
  // ****************************************
  cmlState_t   state_q;       // loader phase
  cmlMode_t    mode_q;        // latched mode
  logic        oscSlow_q;     // latched oscillator choice
  logic [4:0]  initCnt_q;     // init phase counter

  wire inInit  = (state_q == CML_ST_INIT);
  wire inLoad  = (state_q == CML_ST_LOAD);
  wire progLow = !progNS;     // host holds it low at least 500 ns [RQ14]

  // mode decode, only meaningful once latched
  wire isMasterSer = (mode_q == CML_MASTER_SERIAL); // [RQ1]
  wire isMasterPar = (mode_q == CML_MASTER_PAR); // [RQ1]
  wire isAsync     = (mode_q == CML_ASYNC_PERIPH); // [RQ1]
  wire isSlaveSer  = (mode_q == CML_SLAVE_SERIAL); // [RQ1]
  wire isSlavePar  = (mode_q == CML_SLAVE_PARALLEL); // [RQ1]
  // processor-bus modes and the reserved code take no data here
  wire drivesClock = !isSlaveSer && !isSlavePar && (mode_q != CML_RESERVED); // [RQ3]
  wire initDone    = (initCnt_q == INIT_CYCLES);

  // phase sequencing; reset lands straight in init, no pin needed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= CML_ST_INIT; // [RQ11]
    end else if (progLow) begin
      state_q <= CML_ST_INIT; // [RQ9]
    end else begin
      case (state_q)
        CML_ST_INIT: begin
          if (initDone) begin
            state_q <= CML_ST_LOAD; // [RQ9]
          end
        end
        CML_ST_LOAD: begin
          if (bitstreamError) begin
            state_q <= CML_ST_ERROR; // [RQ24]
          end else if (loadFinished) begin
            state_q <= CML_ST_DONE;
          end
        end
        CML_ST_DONE:  state_q <= CML_ST_DONE;
        CML_ST_ERROR: state_q <= CML_ST_ERROR; // [RQ24]
        default:      state_q <= CML_ST_INIT;
      endcase
    end
  end

  // init counter, and strap capture at the end of init
  always_ff @(posedge ref_clk) begin
    if (rst || !inInit || progLow) begin
      initCnt_q <= 5'h00;
    end else if (!initDone) begin
      initCnt_q <= initCnt_q + 5'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q    <= CML_MASTER_SERIAL;
      oscSlow_q <= 1'b1;
    end else if (inInit && initDone && !progLow) begin
      mode_q    <= cmlMode_t'(modePinsS); // [RQ25]
      oscSlow_q <= oscSlowS; // [RQ2]
    end
  end

  // ****************************************
  // internal oscillator and config clock
  // ****************************************
  logic [4:0] divCnt_q;       // half-period counter
  logic       config_clock_q;         // config clock level

  wire [4:0] halfCount = oscSlow_q ? HALF_SLOW : HALF_FAST;      // [RQ2]
  wire       divWrap   = inLoad && drivesClock && (divCnt_q == halfCount - 5'h01);
  wire       riseTick  = divWrap && !config_clock_q;
  wire       fallTick  = divWrap && config_clock_q;

  // divider stops outside loading so the clock parks low
  always_ff @(posedge ref_clk) begin
    if (rst || !inLoad || !drivesClock) begin
      divCnt_q <= 5'h00;
      config_clock_q   <= 1'b0;
    end else if (divWrap) begin
      divCnt_q <= 5'h00;
      config_clock_q   <= !config_clock_q; // [RQ2]
    end else begin
      divCnt_q <= divCnt_q + 5'h01;
    end
  end

  // ****************************************
  // master parallel addressing
  // ****************************************
  logic [2:0]        bitIdx_q;  // config clocks within one byte
  logic [ADDR_W-1:0] addr_q;    // memory address
  logic              rclk_q;    // memory read clock

  wire       mpStep   = isMasterPar && riseTick;
  wire [2:0] bitIdxD  = bitIdx_q + 3'h1;
  wire       byteTick = mpStep && (bitIdx_q == 3'h0);             // rclk rises here

  // read clock high for three config clocks, low for five
  always_ff @(posedge ref_clk) begin
    if (rst || inInit) begin
      bitIdx_q <= 3'h0;
      rclk_q   <= 1'b0;
      addr_q   <= ADDR_RESET; // [RQ6]
    end else if (mpStep) begin
      bitIdx_q <= bitIdxD; // [RQ8]
      rclk_q   <= !bitIdxD[2] && (bitIdxD != 3'h0); // [RQ8]
      if (byteTick) begin
        addr_q <= addr_q + 18'h00001; // [RQ6]
      end
    end
  end

  // ****************************************
  // link domain: slave serial and slave parallel
  // ****************************************
  logic       linkRstS;       // reset seen in link domain
  logic       linkSerS;       // slave serial mode, link side
  logic       linkParS;       // slave parallel mode, link side
  logic       linkAckS;       // ack toggle, link side
  logic [7:0] assemble_q;     // serial byte under assembly
  logic [2:0] linkCnt_q;      // bits assembled
  logic [7:0] linkByte_q;     // finished byte, stable until acked
  logic       linkTgl_q;      // flips per finished byte
  logic       linkAck_q;      // system side ack toggle

  cml_sync #(.W(4)) linkSync (
    .clk     (configClockIn),
    .asyncIn ({rst, inLoad && isSlaveSer, inLoad && isSlavePar, linkAck_q}),
    .syncOut ({linkRstS, linkSerS, linkParS, linkAckS})
  );

  wire linkFree  = (linkTgl_q == linkAckS);       // last byte taken
  wire parSelect = !hostBus.chipSelectLowN && hostBus.chipSelectHigh && !hostBus.writeN;
  wire [7:0] serByte = {serialDataIn, assemble_q[7:1]};           // [RQ5]

  // external clock captures; a byte arriving before ack is lost
  always_ff @(posedge configClockIn) begin
    if (linkRstS) begin
      assemble_q <= 8'h00;
      linkCnt_q  <= 3'h0;
      linkByte_q <= 8'h00;
      linkTgl_q  <= 1'b0;
    end else if (linkSerS) begin
      assemble_q <= serByte; // [RQ3]
      linkCnt_q  <= linkCnt_q + 3'h1;
      if (linkCnt_q == BYTE_LAST && linkFree) begin
        linkByte_q <= serByte;
        linkTgl_q  <= !linkTgl_q;
      end
    end else if (linkParS && parSelect && linkFree) begin
      linkByte_q <= dataIn; // [RQ3]
      linkTgl_q  <= !linkTgl_q;
    end
  end

  logic linkTglS;             // byte toggle, system side
  cml_sync #(.W(1)) tglSync (
    .clk     (ref_clk),
    .asyncIn (linkTgl_q),
    .syncOut (linkTglS)
  );

  // ****************************************
  // processor write path
  // ****************************************
  logic wrPrevN_q;            // previous write strobe
  logic serHoldFull;          // hold register occupied
  logic serBitValid;          // serializer emits a bit
  logic serBit;               // serializer bit

  wire hostSel    = !hostS.chipSelectLowN && hostS.chipSelectHigh;   // [RQ15]
  wire wrRise     = hostS.writeN && !wrPrevN_q;                    // end of write
  wire asyncLoad  = inLoad && isAsync && hostSel && wrRise;
  wire linkPend   = linkTglS ^ linkAck_q;
  wire linkLoad   = inLoad && (isSlaveSer || isSlavePar) && linkPend && !serHoldFull;
  wire serLoad    = asyncLoad || linkLoad || (inLoad && byteTick);  // [RQ4]
  wire [7:0] serByteIn = isMasterPar ? memDataS :                  // [RQ4]
                         isAsync     ? dataS : linkByte_q;
  wire serStep    = (isMasterPar || isAsync) ? riseTick : inLoad;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPrevN_q <= 1'b1;
      linkAck_q <= 1'b0;
    end else begin
      wrPrevN_q <= hostS.writeN;
      if (linkLoad) begin
        linkAck_q <= !linkAck_q;      // releases link capture
      end
    end
  end

  cml_serializer serializer (
    .clk      (ref_clk),
    .clear    (rst || inInit),
    .load     (serLoad),
    .loadByte (serByteIn),
    .holdFull (serHoldFull),
    .step     (serStep),
    .bitValid (serBitValid),
    .bitOut   (serBit)
  );

  // ****************************************
  // output stream and daisy chain
  // ****************************************
  cmlStream_t stream_q;       // bit toward configuration memory
  logic       lastBit_q;      // bit to forward downstream
  logic       daisy_q;        // daisy output level

  wire msTake = inLoad && isMasterSer && riseTick;                 // [RQ10]

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stream_q  <= '0;
      lastBit_q <= 1'b1;
    end else begin
      stream_q.valid    <= msTake || (inLoad && serBitValid);
      stream_q.bitValue <= msTake ? serDinS : serBit; // [RQ10]
      if (msTake || serBitValid) begin
        lastBit_q <= msTake ? serDinS : serBit;
      end
    end
  end

  // downstream sees the bit change on the falling config clock edge
  always_ff @(posedge ref_clk) begin
    if (rst || !(isMasterSer || isMasterPar)) begin
      daisy_q <= 1'b1;
    end else if (fallTick) begin
      daisy_q <= lastBit_q; // [RQ7]
    end
  end

  // ****************************************
  // status and pin registers
  // ****************************************
  logic rdy_q;                // ready/busy
  logic d7Oe_q;               // data bit 7 drive enable
  logic d7_q;                 // data bit 7 level
  logic init_q;               // init status, active low
  logic done_q;               // configuration complete
  logic cclkOe_q;             // config clock drive enable

  // busy covers the write just seen and a full hold register
  wire rdyD  = inLoad && isAsync && !serHoldFull && !asyncLoad && !progLow; // [RQ16]
  wire d7OeD = inLoad && isAsync && hostSel && hostS.writeN && !hostS.readN; // [RQ20]

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdy_q    <= 1'b0;
      d7Oe_q   <= 1'b0;
      d7_q     <= 1'b0;
      init_q   <= 1'b0;
      done_q   <= 1'b0;
      cclkOe_q <= 1'b0;
    end else begin
      rdy_q    <= rdyD; // [RQ16]
      d7Oe_q   <= d7OeD; // [RQ21]
      d7_q     <= rdyD; // [RQ20]
      init_q   <= !(inInit || state_q == CML_ST_ERROR || progLow); // [RQ13]
      done_q   <= (state_q == CML_ST_DONE) && !progLow; // [RQ12]
      cclkOe_q <= !inInit && drivesClock; // [RQ3]
    end
  end

  assign configClockOut    = config_clock_q;
  assign configClockOe     = cclkOe_q;
  assign memAddr           = addr_q;
  assign memReadClock      = rclk_q;
  assign statusDataLineOut = d7_q;
  assign statusDataLineOe  = d7Oe_q;
  assign readyBusy         = rdy_q;
  assign daisyOut          = daisy_q;
  assign initN             = init_q;
  assign done              = done_q;
  assign cfgStream         = stream_q;

endmodule : cml_loader

//--- bench/cml_loader_chk.sv
`timescale 1ns/1ps
// ****
// loader port checker
// ****
module cml_loader_chk
  import cml_pkg::*;
(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              rst,
  // inputs
  input wire logic              programRequestN,
  input wire cmlHostBus_t       hostBus,
  input wire logic              bitstreamError,
  input wire logic              loadFinished,
  // outputs
  input wire logic              configClockOut,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic              readyBusy,
  input wire logic              daisyOut,
  input wire logic              initN,
  input wire logic              done
);
  // one domain
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****
  // assertions
  // ****
  self_init_a: assert property ($fell(rst) && programRequestN |-> ##[8:12] initN)
    else $error("init stuck");
  prog_init_a: assert property ($fell(programRequestN) |-> ##[1:6] !initN)
    else $error("no init on request");
  done_init_a: assert property (done |-> initN)
    else $error("done in init");
  finish_done_a: assert property (loadFinished && !bitstreamError && initN && !done
    && programRequestN |-> ##[1:3] done) else $error("no done");
  error_idle_a: assert property (bitstreamError && initN && !done
    |-> ##[1:3] (!initN && !done) [*8]) else $error("error not held");
  addr_start_a: assert property ($rose(initN) |-> $past(memAddr) == ADDR_RESET)
    else $error("addr not zero");
  addr_step_a: assert property ($changed(memAddr) && memAddr != ADDR_RESET
    |-> memAddr == $past(memAddr) + 18'h1) else $error("addr step");
  busy_write_a: assert property ($rose(hostBus.writeN) && !hostBus.chipSelectLowN
    && hostBus.chipSelectHigh && readyBusy |-> ##[1:6] !readyBusy) else $error("no busy");
  ready_load_a: assert property (readyBusy |-> initN && !done)
    else $error("stray ready");
  daisy_edge_a: assert property ($changed(daisyOut) && initN |-> !configClockOut)
    else $error("daisy on high clock");
  clk_park_a: assert property (!initN && !$past(initN) |-> !configClockOut)
    else $error("clock not parked");
  // scenarios
  cover property ($rose(done));
  cover property ($fell(readyBusy));
  cover property (bitstreamError && initN);
endmodule : cml_loader_chk

bind cml_loader cml_loader_chk u_cml_loader_chk (
  .ref_clk(ref_clk), .rst(rst), .programRequestN(programRequestN), .hostBus(hostBus),
  .bitstreamError(bitstreamError), .loadFinished(loadFinished),
  .configClockOut(configClockOut), .memAddr(memAddr), .readyBusy(readyBusy),
  .daisyOut(daisyOut), .initN(initN), .done(done)
);

//--- bench/cml_mem_model.sv
`timescale 1ns/1ps
// ****
// byte rom, serial rom and link clock
// ****
module cml_mem_model
  import cml_pkg::*;
(
  // link clock request
  input  wire logic              linkEn,
  output logic                   configClockIn,
  // memory side
  input  wire logic [ADDR_W-1:0] memAddr,
  output logic      [7:0]        memData,
  // serial rom side
  input  wire logic              configClockOut,
  input  wire logic              initN,
  input  wire logic              done,
  output logic                   serialDataIn
);
  logic [11:0] ptr = 12'h000;  // serial bit pointer
  logic        lastBit = 1'b0; // last bit shown
  wire  [7:0]  romB = ptr[10:3] ^ 8'hA5;
  // byte rom
  assign memData = memAddr[7:0] ^ 8'hA5;
  // link clock stands still outside frames
  initial configClockIn = 1'b0;
  always #15 configClockIn = linkEn ? ~configClockIn : 1'b0;
  // data moves on the out clock rising edge and the link clock falling edge
  always @(posedge configClockOut) ptr <= ptr + 12'h001;
  always @(negedge configClockIn) ptr <= ptr + 12'h001;
  // init edges reset pointer
  always @(initN) ptr <= 12'h000;
  always @(posedge done) lastBit <= romB[ptr[2:0]];
  // done disables rom, line inverts
  assign serialDataIn = done ? ~lastBit : romB[ptr[2:0]];
endmodule : cml_mem_model

//--- bench/cml_loader_tb.sv
`timescale 1ns/1ps
module cml_loader_tb
  import cml_pkg::*;
;
  // ****
  // signals
  // ****
  logic ref_clk = 1'b0, rst = 1'b1, linkEn = 1'b1, programRequestN = 1'b1;
  logic oscFreqSelect = 1'b0, bitstreamError = 1'b0, loadFinished = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [7:0] dataIn = 8'h00;
  cmlHostBus_t hostBus = cmlHostBus_t'(4'hB); // selects off
  logic configClockIn, configClockOut, configClockOe, serialDataIn, memReadClock;
  logic statusDataLineOut, statusDataLineOe, readyBusy, daisyOut, initN, done;
  logic [ADDR_W-1:0] memAddr;
  logic [7:0] memData;
  cmlStream_t cfgStream;
  int error_cnt = 0, total_checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  cml_loader u_cml_loader (.ref_clk(ref_clk), .rst(rst), .configClockIn(configClockIn),
    .configClockOut(configClockOut), .configClockOe(configClockOe),
    .modeSelectBit0(mode[0]), .modeSelectBit1(mode[1]), .modeSelectBit2(mode[2]),
    .oscFreqSelect(oscFreqSelect), .programRequestN(programRequestN),
    .serialDataIn(serialDataIn), .memAddr(memAddr), .memReadClock(memReadClock),
    .memData(memData), .hostBus(hostBus), .dataIn(dataIn), .readyBusy(readyBusy),
    .statusDataLineOut(statusDataLineOut), .statusDataLineOe(statusDataLineOe),
    .daisyOut(daisyOut), .initN(initN), .done(done), .cfgStream(cfgStream),
    .bitstreamError(bitstreamError), .loadFinished(loadFinished));
  cml_mem_model u_cml_mem_model (.linkEn(linkEn), .configClockIn(configClockIn),
    .memAddr(memAddr), .memData(memData), .configClockOut(configClockOut),
    .initN(initN), .done(done), .serialDataIn(serialDataIn));
  // ****
  // helpers
  // ****
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // bound ran out: end run
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      summarize();
    end
  endtask : tmo
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  // program pulse, wait for load
  task automatic prog(input logic [2:0] m, input logic sel);
    int k;
    @(posedge ref_clk);
    mode <= m;
    oscFreqSelect <= sel;
    programRequestN <= 1'b0;
    cyc(PROG_PULSE_CYC);
    programRequestN <= 1'b1;
    for (k = 0; k < 80 && initN !== 1'b1; k++) @(posedge ref_clk);
    tmo(initN);
  endtask : prog
  task automatic getBits(input int n, output logic [15:0] b);
    int i, k;
    b = 16'h0000;
    for (i = 0; i < n; i++) begin
      for (k = 0; k < 400 && cfgStream.valid !== 1'b1; k++) @(posedge ref_clk);
      tmo(cfgStream.valid);
      b[i] = cfgStream.bitValue;
      @(posedge ref_clk);
    end
  endtask : getBits
  // one write, busy length
  task automatic wr(input logic [7:0] d, output int busy);
    int k;
    @(posedge ref_clk);
    dataIn <= d;
    hostBus <= cmlHostBus_t'(4'h5);
    cyc(3);
    hostBus.writeN <= 1'b1;
    for (k = 0; k < 8 && readyBusy !== 1'b0; k++) @(posedge ref_clk);
    for (busy = 0; busy < 400 && readyBusy !== 1'b1; busy++) @(posedge ref_clk);
    tmo(readyBusy);
  endtask : wr
  // ****
  // scenarios
  // ****
  task automatic t_modes();
    logic [7:0] oeExp = 8'h3D; // slave and reserved codes drive none
    for (int m = 0; m < 8; m++) begin
      prog(m[2:0], 1'b0);
      cyc(2);
      chk("clock oe", configClockOe, oeExp[m]);
      mode <= ~m[2:0];
      cyc(4);
      chk("oe held", configClockOe, oeExp[m]);
    end
  endtask : t_modes
  task automatic t_serial(input logic sel);
    logic [15:0] b;
    int k;
    prog(3'h0, sel);
    getBits(16, b);
    chk("serial bits", b, 16'hA4A5);
    for (k = 1; k < 100 && cfgStream.valid !== 1'b1; k++) @(posedge ref_clk);
    chk("clock period", k, 2 * (sel ? HALF_SLOW : HALF_FAST));
    chk("done low", done, 1'b0);
    loadFinished <= 1'b1;
    cyc(1);
    loadFinished <= 1'b0;
    cyc(3);
    chk("done high", done, 1'b1);
  endtask : t_serial
  task automatic t_par();
    logic [15:0] b;
    logic [ADDR_W-1:0] a;
    logic p;
    int k, r, rc;
    prog(3'h4, 1'b0);
    getBits(16, b);
    chk("parallel bits", b, 16'hA4A5);
    a = memAddr;
    for (k = 0; k < 200 && memAddr === a; k++) @(posedge ref_clk);
    a = memAddr;
    p = memReadClock;
    r = 0;
    rc = 0;
    for (k = 0; k < 200 && memAddr === a; k++) begin
      @(posedge ref_clk);
      r += cfgStream.valid;
      rc += (memReadClock === 1'b1 && p === 1'b0);
      p = memReadClock;
    end
    chk("bits per byte", r, 8);
    chk("read clocks", rc, 1);
    chk("addr step", memAddr, a + 18'h1);
  endtask : t_par
  task automatic t_async();
    logic [15:0] b;
    int s, l;
    prog(3'h5, 1'b0);
    hostBus <= cmlHostBus_t'(4'h6);
    cyc(5);
    chk("d7 oe", statusDataLineOe, 1'b1);
    chk("d7 value", statusDataLineOut, 1'b1);
    hostBus.readN <= 1'b1;
    cyc(5);
    chk("d7 off", statusDataLineOe, 1'b0);
    fork
      getBits(16, b);
      begin
        wr(8'h3C, s);
        wr(8'hC3, l);
      end
    join
    chk("async bits", b, 16'hC33C);
    chk("busy order", s < l, 1'b1);
    bitstreamError <= 1'b1;
    cyc(1);
    bitstreamError <= 1'b0;
    cyc(10);
    chk("error idle", initN, 1'b0);
  endtask : t_async
  task automatic t_slave();
    logic [15:0] b;
    prog(3'h7, 1'b0);
    linkEn <= 1'b1;
    getBits(16, b);
    linkEn <= 1'b0;
    chk("slave bits", b, 16'hE929); // two bits lost to sync
    chk("clock input", configClockOe, 1'b0);
  endtask : t_slave
  // ****
  // main sequence
  // ****
  initial begin
    cyc(3);
    chk("reset daisy", daisyOut, 1'b1);
    rst <= 1'b0;
    cyc(14);
    linkEn <= 1'b0;
    chk("self init", initN, 1'b1);
    t_modes();
    t_serial(1'b0);
    t_serial(1'b1);
    t_par();
    t_async();
    t_slave();
    summarize();
  end
endmodule : cml_loader_tb
